// [design/vic_pkg.sv]
// shared constants for the vectored interrupt controller
package irq_ctl_pkg;
  localparam int unsigned NUM_SRC  = 32;
  localparam int unsigned NUM_SLOT = 16;
  localparam int unsigned SLOT_W   = 4;
  localparam int unsigned SRC_W    = 5;
  localparam int unsigned ADDR_W   = 12;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS   = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_FAST_STATUS  = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_RAW_STATUS   = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_CLASS_SEL    = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_ENABLE       = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_VEC_ADDR     = 12'h030;
  localparam logic [ADDR_W-1:0] OFF_DEF_ADDR     = 12'h034;
  localparam logic [ADDR_W-1:0] OFF_EVT_STATUS   = 12'h038;
  localparam logic [ADDR_W-1:0] OFF_EVT_MASK     = 12'h03c;
  localparam logic [ADDR_W-1:0] OFF_SLOT_ADDR_0  = 12'h100;
  localparam logic [ADDR_W-1:0] OFF_SLOT_CTRL_0  = 12'h200;
  localparam logic [ADDR_W-1:0] SLOT_BANK_MASK   = 12'hf00;

  // slot control field layout
  localparam int unsigned SLOT_SRC_LSB = 0;
  localparam int unsigned SLOT_EN_BIT  = 5;

  // event status bit positions
  localparam int unsigned EVT_FAST_BIT = 0;
  localparam int unsigned EVT_IRQ_BIT = 1;
  localparam int unsigned EVT_W       = 2;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage : irq_ctl_pkg

// [design/vic_req_if.sv]
// synchronised request lines shared between the sampler and the core
`timescale 1ns/1ns
interface req_lines_if #(parameter int unsigned N = 32);
  logic [N-1:0] req;
  modport src (output req);
  modport dst (input  req);
endinterface : req_lines_if

// [design/req_sync.sv]
// two-flop synchroniser for the peripheral request lines
`timescale 1ns/1ns
module req_sync #(
  parameter int unsigned N = 32
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] raw_req,
  req_lines_if.src          out
);
  logic [N-1:0] meta_q;
  logic [N-1:0] sync_q;

  // levels are sampled every clock, so a dropped request clears here too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw_req;
      sync_q <= meta_q;
    end
  end

  assign out.req = sync_q;
endmodule : req_sync

// [design/slot_prio.sv]
// fixed-priority pick among vectored slots, lowest number wins
`timescale 1ns/1ns
module slot_prio #(
  parameter int unsigned N = 16,
  parameter int unsigned W = 4
) (
  input  wire logic [N-1:0] hit,
  output logic              any,
  output logic [W-1:0]      idx
);
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (hit[i]) begin
        any = 1'b1;
        idx = W'(i);
      end
    end
  end
endmodule : slot_prio

// [design/vectored_irq_controller.sv]
// vectored interrupt controller with apb register access
`timescale 1ns/1ns
module vectored_irq_controller #(
  parameter int unsigned NUM_SRC  = irq_ctl_pkg::NUM_SRC,
  parameter int unsigned NUM_SLOT = irq_ctl_pkg::NUM_SLOT
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [NUM_SRC-1:0] periph_req,
  output logic                    fast_interrupt_request,
  output logic                    normal_irq,
  output logic                    event_irq
);
  localparam int unsigned SW = irq_ctl_pkg::SLOT_W;
  localparam int unsigned XW = irq_ctl_pkg::SRC_W;
  localparam int unsigned EW = irq_ctl_pkg::EVT_W;

  req_lines_if #(.N(NUM_SRC)) req_bus ();

  logic [NUM_SRC-1:0]       class_fast_q;
  logic [NUM_SRC-1:0]       enable_q;
  logic [31:0]              slot_addr_q [NUM_SLOT];
  logic [XW-1:0]            slot_src_q  [NUM_SLOT];
  logic [NUM_SLOT-1:0]      slot_en_q;
  logic [31:0]              def_addr_q;
  logic [EW-1:0]            evt_status_q;
  logic [EW-1:0]            evt_mask_q;
  logic                     fast_prev_q;
  logic                     irq_prev_q;

  logic [NUM_SRC-1:0]       active;
  logic [NUM_SRC-1:0]       fast_status;
  logic [NUM_SRC-1:0]       irq_status;
  logic [NUM_SLOT-1:0]      slot_hit;
  logic                     slot_any;
  logic [SW-1:0]            slot_win;
  logic [31:0]              vec_addr;
  logic                     fast_d;
  logic                     irq_d;
  logic                     setup_ok;
  logic                     wr_en;
  logic                     rd_en;
  logic [31:0]              rd_data;
  logic                     rd_err;
  logic [SW-1:0]            bank_idx;
  logic                     addr_bank;
  logic                     ctrl_bank;
  logic [EW-1:0]            evt_set;

  req_sync #(.N(NUM_SRC)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw_req (periph_req),
    .out     (req_bus.src)
  );

  // classing of the synchronised levels
  assign active      = req_bus.req & enable_q;
  assign fast_status = active & class_fast_q;
  assign irq_status  = active & ~class_fast_q;
  assign fast_d      = |fast_status;
  // fast-class sources never reach the normal line, even if also slotted
  assign irq_d       = |irq_status;

  // a slot hits only when its source is live and not fast-classed
  always_comb begin
    for (int s = 0; s < NUM_SLOT; s++) begin
      slot_hit[s] = slot_en_q[s] && irq_status[slot_src_q[s]];
    end
  end

  slot_prio #(.N(NUM_SLOT), .W(SW)) u_prio (
    .hit (slot_hit),
    .any (slot_any),
    .idx (slot_win)
  );

  // combinational so the read sees priority of this very cycle
  assign vec_addr = slot_any ? slot_addr_q[slot_win] : def_addr_q;

  // apb: single access phase, zero wait states
  assign setup_ok = psel && penable;
  assign wr_en    = setup_ok && pwrite;
  assign rd_en    = setup_ok && !pwrite;
  assign bank_idx = paddr[5:2];
  // a slot bank spans 64 bytes, so everything above the word index names the bank
  assign addr_bank = (paddr >> 6) == (irq_ctl_pkg::OFF_SLOT_ADDR_0 >> 6);
  assign ctrl_bank = (paddr >> 6) == (irq_ctl_pkg::OFF_SLOT_CTRL_0 >> 6);

  always_comb begin
    rd_data = irq_ctl_pkg::RESET_WORD;
    rd_err  = 1'b0;
    if (addr_bank) begin
      rd_data = slot_addr_q[bank_idx];
    end else if (ctrl_bank) begin
      rd_data[irq_ctl_pkg::SLOT_EN_BIT]        = slot_en_q[bank_idx];
      rd_data[irq_ctl_pkg::SLOT_SRC_LSB +: XW] = slot_src_q[bank_idx];
    end else begin
      unique case (paddr)
        irq_ctl_pkg::OFF_IRQ_STATUS:  rd_data = 32'(irq_status);
        irq_ctl_pkg::OFF_FAST_STATUS: rd_data = 32'(fast_status);
        irq_ctl_pkg::OFF_RAW_STATUS:  rd_data = 32'(req_bus.req);
        irq_ctl_pkg::OFF_CLASS_SEL:   rd_data = 32'(class_fast_q);
        irq_ctl_pkg::OFF_ENABLE:      rd_data = 32'(enable_q);
        irq_ctl_pkg::OFF_VEC_ADDR:    rd_data = vec_addr;
        irq_ctl_pkg::OFF_DEF_ADDR:    rd_data = def_addr_q;
        irq_ctl_pkg::OFF_EVT_STATUS:  rd_data = 32'(evt_status_q);
        irq_ctl_pkg::OFF_EVT_MASK:    rd_data = 32'(evt_mask_q);
        default:                      rd_err  = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= irq_ctl_pkg::RESET_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // answer registered in the setup cycle, ready in the access phase
      pready  <= psel && !penable;
      pslverr <= psel && !penable && rd_err;
      prdata  <= (psel && !penable && !pwrite) ? rd_data : irq_ctl_pkg::RESET_WORD;
    end
  end

  // writes land on the access edge where pready is high
  logic acc_wr;
  assign acc_wr = wr_en && pready && !pslverr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      class_fast_q <= '0;
      enable_q     <= '0;
      def_addr_q   <= irq_ctl_pkg::RESET_WORD;
    end else if (acc_wr) begin
      unique case (paddr)
        irq_ctl_pkg::OFF_CLASS_SEL: class_fast_q <= pwdata[NUM_SRC-1:0];
        irq_ctl_pkg::OFF_ENABLE:    enable_q     <= pwdata[NUM_SRC-1:0];
        irq_ctl_pkg::OFF_DEF_ADDR:  def_addr_q   <= pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < NUM_SLOT; s++) begin
        slot_addr_q[s] <= irq_ctl_pkg::RESET_WORD;
        slot_src_q[s]  <= '0;
      end
      slot_en_q <= '0;
    end else if (acc_wr && addr_bank) begin
      slot_addr_q[bank_idx] <= pwdata;
    end else if (acc_wr && ctrl_bank) begin
      slot_src_q[bank_idx] <= pwdata[irq_ctl_pkg::SLOT_SRC_LSB +: XW];
      slot_en_q[bank_idx]  <= pwdata[irq_ctl_pkg::SLOT_EN_BIT];
    end
  end

  // processor lines straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_interrupt_request <= 1'b0;
      normal_irq             <= 1'b0;
      fast_prev_q            <= 1'b0;
      irq_prev_q             <= 1'b0;
    end else begin
      fast_interrupt_request <= fast_d;
      normal_irq             <= irq_d;
      fast_prev_q            <= fast_d;
      irq_prev_q             <= irq_d;
    end
  end

  // sticky rising-edge events, cleared by reading; set wins over clear
  assign evt_set[irq_ctl_pkg::EVT_FAST_BIT] = fast_d && !fast_prev_q;
  assign evt_set[irq_ctl_pkg::EVT_IRQ_BIT]  = irq_d && !irq_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status_q <= '0;
      evt_mask_q   <= '0;
    end else begin
      if (rd_en && pready && paddr == irq_ctl_pkg::OFF_EVT_STATUS) begin
        // drop only what the read reported; a rise during the setup cycle survives
        evt_status_q <= (evt_status_q & ~prdata[EW-1:0]) | evt_set;
      end else begin
        evt_status_q <= evt_status_q | evt_set;
      end
      if (acc_wr && paddr == irq_ctl_pkg::OFF_EVT_MASK) begin
        evt_mask_q <= pwdata[EW-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_irq <= 1'b0;
    end else begin
      event_irq <= |(evt_status_q & evt_mask_q);
    end
  end
endmodule : vectored_irq_controller

// [sim/irq_ctl_chk.sv]
// port-level assertions for the interrupt controller
`timescale 1ns/1ns
module irq_ctl_chk #(
  parameter int unsigned NUM_SRC = 32
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [NUM_SRC-1:0] periph_req,
  input wire logic               fast_interrupt_request,
  input wire logic               normal_irq,
  input wire logic               event_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_setup_ready; psel && !penable |=> pready; endproperty
  a_setup_ready: assert property (p_setup_ready) else $error("no answer after setup");
  property p_ready_access; pready |-> psel && penable; endproperty
  a_ready_access: assert property (p_ready_access) else $error("answer outside access");
  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("answer held two cycles");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without answer");
  property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
  property p_fast_idle; (periph_req == '0)[*3] |=> !fast_interrupt_request; endproperty
  a_fast_idle: assert property (p_fast_idle) else $error("fast line without request");
  property p_norm_idle; (periph_req == '0)[*3] |=> !normal_irq; endproperty
  a_norm_idle: assert property (p_norm_idle) else $error("normal line without request");
  property p_fast_cause; $rose(fast_interrupt_request) |-> $past(periph_req, 3) != '0; endproperty
  a_fast_cause: assert property (p_fast_cause) else $error("fast rise without cause");
  property p_norm_cause; $rose(normal_irq) |-> $past(periph_req, 3) != '0; endproperty
  a_norm_cause: assert property (p_norm_cause) else $error("normal rise without cause");
endmodule : irq_ctl_chk

bind vectored_irq_controller irq_ctl_chk #(.NUM_SRC(NUM_SRC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .periph_req(periph_req), .fast_interrupt_request(fast_interrupt_request),
  .normal_irq(normal_irq), .event_irq(event_irq));

// [sim/core_model.sv]
// processor-side model: which interrupt line it would serve
`timescale 1ns/1ns
module core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       fast_line,
  input  wire logic       normal_line,
  output logic      [1:0] serving_q
);
  // fast line is taken first when both are raised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) serving_q <= 2'h0;
    else if (fast_line) serving_q <= 2'h2;
    else if (normal_line) serving_q <= 2'h1;
    else serving_q <= 2'h0;
  end
endmodule : core_model

// [sim/vectored_irq_controller_tb.sv]
// self-checking bench for the interrupt controller
`timescale 1ns/1ns
module vectored_irq_controller_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        fast_interrupt_request, normal_irq, event_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, periph_req, rd;
  logic [1:0]  serving;
  int          num_errors, n_checks;

  vectored_irq_controller dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_req(periph_req), .event_irq(event_irq),
    .fast_interrupt_request(fast_interrupt_request), .normal_irq(normal_irq));
  core_model core (.pclk(pclk), .presetn(presetn), .fast_line(fast_interrupt_request),
    .normal_line(normal_irq), .serving_q(serving));

  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  task close_out;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic err);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    // no cycle limit here: a hung answer is left to the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic e;
    apb(1'h1, a, d, e);
  endtask : wr

  task rdc(input logic [11:0] a, input logic [31:0] exp);
    logic e;
    apb(1'h0, a, 32'h0, e);
    chk(rd, exp);
  endtask : rdc

  // one level per peripheral; long enough for sync and output flop
  task req(input logic [31:0] v);
    @(posedge pclk);
    periph_req <= v;
    repeat (5) @(posedge pclk);
  endtask : req

  task outs(input logic [1:0] exp);
    chk({30'h0, fast_interrupt_request, normal_irq}, {30'h0, exp});
    chk({30'h0, serving}, {30'h0, exp[1], exp[0] & ~exp[1]});
  endtask : outs

  task t_regs;
    logic e;
    rdc(irq_ctl_pkg::OFF_CLASS_SEL, irq_ctl_pkg::RESET_WORD);
    rdc(irq_ctl_pkg::OFF_EVT_MASK, irq_ctl_pkg::RESET_WORD);
    apb(1'h1, 12'h0f0, 32'h5, e);
    chk({31'h0, e}, 32'h1);
    apb(1'h0, 12'h0f0, 32'h0, e);
    chk({31'h0, e}, 32'h1);
    chk(rd, irq_ctl_pkg::RESET_WORD);
    wr(irq_ctl_pkg::OFF_DEF_ADDR, 32'h0dd0);
    rdc(irq_ctl_pkg::OFF_DEF_ADDR, 32'h0dd0);
  endtask : t_regs

  task t_fast;
    wr(irq_ctl_pkg::OFF_ENABLE, 32'hffff_ffff);
    wr(irq_ctl_pkg::OFF_CLASS_SEL, 32'h3);
    req(32'h2);
    outs(2'h2);
    rdc(irq_ctl_pkg::OFF_FAST_STATUS, 32'h2);
    req(32'h23);
    outs(2'h3);
    rdc(irq_ctl_pkg::OFF_FAST_STATUS, 32'h3);
    rdc(irq_ctl_pkg::OFF_IRQ_STATUS, 32'h20);
    req(32'h20);
    outs(2'h1);
    req(32'h0);
    outs(2'h0);
  endtask : t_fast

  task t_vec;
    wr(irq_ctl_pkg::OFF_CLASS_SEL, 32'h0);
    wr(irq_ctl_pkg::OFF_SLOT_ADDR_0 + 12'h00c, 32'h0a30);
    wr(irq_ctl_pkg::OFF_SLOT_CTRL_0 + 12'h00c, 32'h25);
    wr(irq_ctl_pkg::OFF_SLOT_ADDR_0 + 12'h01c, 32'h0a70);
    wr(irq_ctl_pkg::OFF_SLOT_CTRL_0 + 12'h01c, 32'h26);
    req(32'h40);
    rdc(irq_ctl_pkg::OFF_VEC_ADDR, 32'h0a70);
    req(32'h60);
    rdc(irq_ctl_pkg::OFF_VEC_ADDR, 32'h0a30);
    req(32'h40);
    rdc(irq_ctl_pkg::OFF_VEC_ADDR, 32'h0a70);
    req(32'h200);
    rdc(irq_ctl_pkg::OFF_VEC_ADDR, 32'h0dd0);
    outs(2'h1);
    wr(irq_ctl_pkg::OFF_SLOT_CTRL_0 + 12'h00c, 32'h29);
    rdc(irq_ctl_pkg::OFF_VEC_ADDR, 32'h0a30);
    wr(irq_ctl_pkg::OFF_CLASS_SEL, 32'h200);
    repeat (4) @(posedge pclk);
    outs(2'h2);
    rdc(irq_ctl_pkg::OFF_VEC_ADDR, 32'h0dd0);
    req(32'h0);
  endtask : t_vec

  // both lines rose in earlier scenarios, so both sticky bits wait here
  task t_evt;
    wr(irq_ctl_pkg::OFF_CLASS_SEL, 32'h0);
    rdc(irq_ctl_pkg::OFF_EVT_STATUS, 32'h3);
    rdc(irq_ctl_pkg::OFF_EVT_STATUS, 32'h0);
    wr(irq_ctl_pkg::OFF_EVT_MASK, 32'h2);
    req(32'h100);
    chk({31'h0, event_irq}, 32'h1);
    rdc(irq_ctl_pkg::OFF_EVT_STATUS, 32'h2);
    repeat (3) @(posedge pclk);
    chk({31'h0, event_irq}, 32'h0);
    wr(irq_ctl_pkg::OFF_EVT_MASK, 32'h0);
    req(32'h0);
    req(32'h100);
    chk({31'h0, event_irq}, 32'h0);
    rdc(irq_ctl_pkg::OFF_EVT_STATUS, 32'h2);
  endtask : t_evt

  // reset in mid-run with a request standing: lines drop, settings clear
  task t_rst;
    wr(irq_ctl_pkg::OFF_CLASS_SEL, 32'h100);
    req(32'h100);
    outs(2'h2);
    @(posedge pclk);
    presetn <= 1'h0;
    @(posedge pclk);
    chk({29'h0, fast_interrupt_request, normal_irq, event_irq}, 32'h0);
    @(posedge pclk);
    presetn <= 1'h1;
    rdc(irq_ctl_pkg::OFF_CLASS_SEL, irq_ctl_pkg::RESET_WORD);
    rdc(irq_ctl_pkg::OFF_VEC_ADDR, irq_ctl_pkg::RESET_WORD);
    repeat (4) @(posedge pclk);
    outs(2'h0);
    req(32'h0);
  endtask : t_rst

  initial begin
    {psel, penable, pwrite, paddr, pwdata, periph_req, presetn} = '0;
    num_errors = 0;
    n_checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_fast;
    t_vec;
    t_evt;
    t_rst;
    close_out;
  end

  initial begin
    #100000;
    num_errors++;
    close_out;
  end
endmodule : vectored_irq_controller_tb
